/* File: shared/backlight_seq_pkg.sv */
package backlight_seq_pkg;
    localparam int unsigned CLOCK_MHZ         = 100;
    localparam int unsigned STRING_COUNT      = 6;
    // Enable-low filter before shutdown
    localparam int unsigned ENABLE_LOW_MS     = 32;
    localparam int unsigned ENABLE_LOW_CYCLES = ENABLE_LOW_MS * 1000 * 1000 / 10;
    // Start-up charge timeout
    localparam int unsigned CHARGE_TIMEOUT_MS     = 32;
    localparam int unsigned CHARGE_TIMEOUT_CYCLES = CHARGE_TIMEOUT_MS * 1000 * 1000 / 10;
    // Sustained over-current time
    localparam int unsigned OVERCURRENT_MS     = 16;
    localparam int unsigned OVERCURRENT_CYCLES = OVERCURRENT_MS * 1000 * 1000 / 10;
    // Soft-start reference ramp
    localparam int unsigned REF_WIDTH      = 8;
    localparam logic [7:0]  REF_FULL       = 8'hff;
    localparam int unsigned REF_STEP_CYCLES = 64;
    localparam int unsigned TIMER_WIDTH    = 23;
    localparam logic [5:0]  STRINGS_RESET  = 6'h00;

    typedef enum logic [5:0] {
        st_off      = 6'b000001,
        st_charge   = 6'b000010,
        st_isolate  = 6'b000100,
        st_soft     = 6'b001000,
        st_run      = 6'b010000,
        st_latched  = 6'b100000
    } seq_state_type;
endpackage

/* File: rtl/backlight_fault_sequencer.sv */
// Function
// - Enable high wakes the device and starts the start-up sequence.
// - First phase: charge path on, isolation gate high so switch stays off.
// - Output within 2 V of battery: open charge path, gate low.
// - Switching starts only after isolation is on, with a ramped reference.
// - Enable held low for 32 ms shuts the device down.
// - Current limit turns switch off until the next switching cycle.
// - Over-current for 16 ms at full dimming latches off.
// - Output 1 V below battery: isolation off, latched shutdown.
// - No charge within 32 ms: latched shutdown, isolation never turned on.
// - Regulator variants: at output over-voltage, drop zero-current strings.
// - Regulator variants: open-string shutdown only when every string not already excluded is open.
// - External-supply variant: any open string latches shutdown.
// - Over-voltage with current below target: regulate output at that level.
// - Regulator variants: string node over 17 V disables only that sink.
// - External-supply variant: any string over-voltage latches shutdown.
// - Regulator variants: string shorted to ground excluded right after enable.
// - Regulator variants: unconnected string excluded once output hits over-voltage.
// - External-supply variant: 10 kohm-grounded string excluded after enable.
// - Battery under-voltage disables; recovery with hysteresis restarts.
`timescale 1ns/1ns
module backlight_fault_sequencer
    import backlight_seq_pkg::*;
#(
    parameter bit          EXTERNAL_SUPPLY   = 1'b0,
    parameter int unsigned ENABLE_LOW_LIMIT  = ENABLE_LOW_CYCLES,
    parameter int unsigned CHARGE_LIMIT      = CHARGE_TIMEOUT_CYCLES,
    parameter int unsigned OVERCURRENT_LIMIT = OVERCURRENT_CYCLES
)
(
    input  wire logic                    clock,
    input  wire logic                    reset_n,
    input  wire logic                    enable_pin,
    input  wire logic                    battery_ok,
    input  wire logic                    output_near_battery,
    input  wire logic                    output_below_battery,
    input  wire logic                    output_overvoltage,
    input  wire logic                    current_limit,
    input  wire logic                    cycle_start,
    input  wire logic                    full_dimming,
    input  wire logic [STRING_COUNT-1:0] string_no_current,
    input  wire logic [STRING_COUNT-1:0] string_overvoltage,
    input  wire logic [STRING_COUNT-1:0] string_grounded,
    input  wire logic [STRING_COUNT-1:0] string_below_target,
    output logic                         isolation_gate_high,
    output logic                         startup_charge_path,
    output logic                         switch_enable,
    output logic                         power_switch_on,
    output logic                         regulate_at_overvoltage,
    output logic [REF_WIDTH-1:0]         soft_start_ref,
    output logic [STRING_COUNT-1:0]      string_sink_node,
    output logic                         fault_latched
);
    localparam int unsigned SYNC_WIDTH = 5 + 4 * STRING_COUNT;

    // Two-stage synchronisers for comparator levels
    logic [SYNC_WIDTH-1:0] meta_q;
    logic [SYNC_WIDTH-1:0] sync_q;
    wire  [SYNC_WIDTH-1:0] raw_in = {enable_pin, battery_ok, output_near_battery,
                                     output_below_battery, output_overvoltage,
                                     string_no_current, string_overvoltage,
                                     string_grounded, string_below_target};

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= raw_in;
            sync_q <= meta_q;
        end
    end

    wire                    en_s    = sync_q[SYNC_WIDTH-1];
    wire                    bat_ok  = sync_q[SYNC_WIDTH-2];
    wire                    near_s  = sync_q[SYNC_WIDTH-3];
    wire                    below_s = sync_q[SYNC_WIDTH-4];
    wire                    ov_s    = sync_q[SYNC_WIDTH-5];
    wire [STRING_COUNT-1:0] nocur_s = sync_q[4*STRING_COUNT-1:3*STRING_COUNT];
    wire [STRING_COUNT-1:0] sov_s   = sync_q[3*STRING_COUNT-1:2*STRING_COUNT];
    wire [STRING_COUNT-1:0] gnd_s   = sync_q[2*STRING_COUNT-1:STRING_COUNT];
    wire [STRING_COUNT-1:0] low_s   = sync_q[STRING_COUNT-1:0];

    seq_state_type           state_q, state_d;
    logic                    en_prev_q;
    logic [TIMER_WIDTH-1:0]  en_low_q, charge_q, oc_q;
    logic [6:0]              ramp_div_q;
    logic [REF_WIDTH-1:0]    ref_q;
    logic [STRING_COUNT-1:0] excluded_q, excluded_d;
    logic                    switch_block_q;
    logic                    latched_q;

    // Enable: high wakes; low for the filter time shuts down
    wire en_rise     = en_s & ~en_prev_q;
    wire en_shutdown = (en_low_q == TIMER_WIDTH'(ENABLE_LOW_LIMIT));
    wire charge_to   = (charge_q == TIMER_WIDTH'(CHARGE_LIMIT));
    wire oc_to       = (oc_q == TIMER_WIDTH'(OVERCURRENT_LIMIT));
    wire active      = (state_q == st_isolate) | (state_q == st_soft) | (state_q == st_run);

    // Per-string exclusion, variant-dependent
    wire [STRING_COUNT-1:0] open_now  = ov_s ? nocur_s : '0;
    wire [STRING_COUNT-1:0] early_gnd = (state_q == st_charge) ? gnd_s : '0;
    wire all_open   = &(excluded_q | open_now);
    wire var_fault  = EXTERNAL_SUPPLY ? ((|(open_now & ~excluded_q)) | (|(sov_s & ~excluded_q)))
                                      : all_open;
    wire short_flt  = active & below_s;
    wire any_latch  = short_flt | (active & oc_to) | ((state_q == st_charge) & charge_to)
                    | (active & var_fault);

    always_comb
    begin
        excluded_d = excluded_q | early_gnd;
        if (active)
        begin
            excluded_d = excluded_d | open_now;
            if (!EXTERNAL_SUPPLY)
            begin
                excluded_d = excluded_d | sov_s;
            end
        end
    end

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            st_off:     if (en_s && bat_ok) state_d = st_charge;
            st_charge:  if (near_s) state_d = st_isolate;
            st_isolate: state_d = st_soft;
            st_soft:    if (ref_q == REF_FULL) state_d = st_run;
            st_run:     state_d = st_run;
            st_latched: if (en_rise) state_d = st_charge;
        endcase
        if (any_latch)
        begin
            state_d = st_latched;
        end
        if (!bat_ok || en_shutdown)
        begin
            state_d = st_off;
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q    <= st_off;
            en_prev_q  <= 1'b0;
            en_low_q   <= '0;
            charge_q   <= '0;
            oc_q       <= '0;
            ramp_div_q <= '0;
            ref_q      <= '0;
            excluded_q <= STRINGS_RESET;
        end
        else
        begin
            state_q   <= state_d;
            en_prev_q <= en_s;
            en_low_q  <= (en_s || en_shutdown) ? '0 : en_low_q + 1'b1;
            charge_q  <= (state_q != st_charge) ? '0 : charge_q + 1'b1;
            // Only full-duty current limiting counts toward the latch
            oc_q      <= (active && current_limit && full_dimming && !oc_to)
                         ? oc_q + 1'b1 : '0;
            // Wraps at the step length so one reference step spans exactly that many cycles
            ramp_div_q <= (ramp_div_q == 7'(REF_STEP_CYCLES - 1)) ? '0 : ramp_div_q + 1'b1;
            if (state_q != st_soft && state_q != st_run)
            begin
                ref_q <= '0;
            end
            else if (ramp_div_q == 7'(REF_STEP_CYCLES - 1) && ref_q != REF_FULL)
            begin
                ref_q <= ref_q + 1'b1;
            end
            excluded_q <= (state_q == st_off || state_q == st_latched) ? STRINGS_RESET
                                                                     : excluded_d;
        end
    end

    // Cycle-by-cycle limit: blocked until next cycle start
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            switch_block_q <= 1'b0;
        end
        else if (cycle_start)
        begin
            switch_block_q <= 1'b0;
        end
        else if (current_limit)
        begin
            switch_block_q <= 1'b1;
        end
    end

    // Registered outputs
    wire sw_run = (state_q == st_soft) | (state_q == st_run);
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            isolation_gate_high     <= 1'b1;
            startup_charge_path     <= 1'b0;
            switch_enable           <= 1'b0;
            power_switch_on         <= 1'b0;
            regulate_at_overvoltage <= 1'b0;
            soft_start_ref          <= '0;
            string_sink_node        <= '0;
            latched_q               <= 1'b0;
        end
        else
        begin
            isolation_gate_high     <= ~active;
            startup_charge_path     <= (state_q == st_charge);
            switch_enable           <= sw_run;
            // Current limit acts combinationally on the next edge to cut the pulse fast
            power_switch_on         <= sw_run & ~current_limit & (cycle_start | ~switch_block_q);
            regulate_at_overvoltage <= active & ov_s & (|(low_s & ~excluded_q));
            soft_start_ref          <= ref_q;
            string_sink_node        <= active ? ~excluded_d : '0;
            latched_q               <= (state_q == st_latched);
        end
    end

    assign fault_latched = latched_q;
endmodule

/* File: tb/seq_checker_assertions.sv */
`timescale 1ns/1ns
module seq_checker
    import backlight_seq_pkg::*;
#(parameter int unsigned ENABLE_LOW_LIMIT = 50)
(
    input wire logic                    clock,
    input wire logic                    reset_n,
    input wire logic                    enable_pin,
    input wire logic                    output_near_battery,
    input wire logic                    output_below_battery,
    input wire logic                    current_limit,
    input wire logic                    cycle_start,
    input wire logic [STRING_COUNT-1:0] string_overvoltage,
    input wire logic                    isolation_gate_high,
    input wire logic                    startup_charge_path,
    input wire logic                    switch_enable,
    input wire logic                    power_switch_on,
    input wire logic [STRING_COUNT-1:0] string_sink_node,
    input wire logic                    fault_latched
);
    logic [7:0] low_q;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // Saturates so a long low never wraps back into range
    always_ff @(posedge clock or negedge reset_n)
        if (!reset_n) low_q <= 8'h00;
        else if (enable_pin) low_q <= 8'h00;
        else if (low_q != 8'hff) low_q <= low_q + 8'h01;
    a_gate_while_charging: assert property (startup_charge_path |-> isolation_gate_high)
        else $error("gate low while charging");
    a_charge_exit: assert property ((startup_charge_path && output_near_battery)[*3]
        |-> ##[1:3] !isolation_gate_high && !startup_charge_path) else $error("no isolate");
    a_switch_isolated: assert property (switch_enable |-> !isolation_gate_high)
        else $error("switching before isolation");
    a_enable_low_off: assert property (low_q == ENABLE_LOW_LIMIT + 8
        |-> !switch_enable && isolation_gate_high && !fault_latched) else $error("not off");
    a_limit_blocks: assert property ((current_limit && !cycle_start)[*3]
        |-> !power_switch_on) else $error("switch on at limit");
    a_latched_safe: assert property (fault_latched
        |-> isolation_gate_high && !switch_enable && !startup_charge_path) else $error("latch");
    a_short_latch: assert property ((output_below_battery && !isolation_gate_high
        && enable_pin)[*3] |-> ##[1:3] fault_latched) else $error("short not latched");
    a_string_ov_sink: assert property ((switch_enable && |string_overvoltage
        && $stable(string_overvoltage))[*5] |-> (string_sink_node & string_overvoltage) == '0)
        else $error("sink left on");
endmodule
bind backlight_fault_sequencer seq_checker #(.ENABLE_LOW_LIMIT(ENABLE_LOW_LIMIT))
    seq_checker_i (.*);

/* File: tb/power_stage_model.sv */
`timescale 1ns/1ns
module power_stage_model
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic startup_charge_path,
    input wire logic isolation_gate_high,
    input wire logic output_short,
    output logic     output_near_battery,
    output logic     output_below_battery
);
    logic [3:0] level_q;
    // Cap charges only through the start-up path; bleeds off in shutdown
    always_ff @(posedge clock or negedge reset_n)
        if (!reset_n || output_short) level_q <= 4'h0;
        else if (startup_charge_path && level_q != 4'hf) level_q <= level_q + 4'h1;
        else if (isolation_gate_high && !startup_charge_path) level_q <= 4'h0;
    assign output_near_battery  = level_q > 4'h8;
    assign output_below_battery = output_short && !isolation_gate_high;
endmodule

/* File: tb/backlight_fault_sequencer_tb.sv */
`timescale 1ns/1ns
module backlight_fault_sequencer_tb;
    logic clock = 1'b0, reset_n = 1'b0, enable_pin = 1'b0, battery_ok = 1'b1;
    logic current_limit = 1'b0, full_dimming = 1'b0, output_short = 1'b0;
    logic output_overvoltage = 1'b0, output_near_battery, output_below_battery;
    logic [5:0] string_overvoltage = 6'h00, string_grounded = 6'h00;
    logic [5:0] string_no_current = 6'h00, string_below_target = 6'h00, string_sink_node;
    logic isolation_gate_high, startup_charge_path, switch_enable, power_switch_on;
    logic regulate_at_overvoltage, fault_latched, cycle_start;
    logic [7:0] soft_start_ref;
    logic [1:0] phase_q = 2'h0;
    int error_cnt = 0;
    int n_tests = 0;
    int k;
    wire [3:0] flags = {fault_latched, switch_enable, isolation_gate_high, startup_charge_path};
    always #5 clock = ~clock;
    always @(posedge clock) phase_q <= phase_q + 2'h1;
    assign cycle_start = (phase_q == 2'h3);
    backlight_fault_sequencer #(.ENABLE_LOW_LIMIT(50), .CHARGE_LIMIT(100),
        .OVERCURRENT_LIMIT(40)) backlight_fault_sequencer_i (.*);
    power_stage_model power_stage_model_i (.*);
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_for(input int b, input logic lvl, input int n, input string name);
        for (k = 0; k < n && flags[b] !== lvl; k++) @(negedge clock);
        check(name, {7'h00, lvl}, {7'h00, flags[b]});
    endtask
    // Low far shorter than the shutdown filter: only the rising edge matters
    task automatic restart();
        @(posedge clock) enable_pin <= 1'b0;
        repeat (4) @(posedge clock);
        enable_pin <= 1'b1;
        wait_for(2, 1'b1, 300, "restart");
        check("latch_clear", 8'h00, fault_latched);
    endtask
    task automatic t_start();
        @(posedge clock) string_grounded <= 6'h01;
        enable_pin <= 1'b1;
        wait_for(0, 1'b1, 10, "charge_path");
        check("gate_charging", 8'h01, isolation_gate_high);
        wait_for(1, 1'b0, 40, "gate_on");
        check("charge_open", 8'h00, startup_charge_path);
        for (k = 0; k < 17000 && soft_start_ref !== 8'hff; k++) @(negedge clock);
        check("ref_top", 8'hff, soft_start_ref);
        check("sinks", 8'h3e, string_sink_node);
        @(posedge clock) string_overvoltage <= 6'h02;
        repeat (8) @(negedge clock);
        check("sink_ov", 8'h3c, string_sink_node);
        $display("t_start done");
    endtask
    task automatic t_strings();
        @(posedge clock) output_overvoltage <= 1'b1;
        string_no_current <= 6'h04;
        string_below_target <= 6'h08;
        repeat (6) @(negedge clock);
        check("sink_open", 8'h38, string_sink_node);
        check("reg_at_ov", 8'h01, regulate_at_overvoltage);
        check("one_open_ok", 8'h00, fault_latched);
        @(posedge clock) string_no_current <= 6'h3c;
        wait_for(3, 1'b1, 10, "all_open");
        @(posedge clock) output_overvoltage <= 1'b0;
        string_no_current <= 6'h00;
        string_below_target <= 6'h00;
        restart();
        $display("t_strings done");
    endtask
    task automatic t_faults();
        @(posedge clock) full_dimming <= 1'b1;
        current_limit <= 1'b1;
        repeat (30) @(negedge clock);
        check("early_latch", 8'h00, fault_latched);
        wait_for(3, 1'b1, 30, "oc_latch");
        @(posedge clock) current_limit <= 1'b0;
        restart();
        @(posedge clock) output_short <= 1'b1;
        wait_for(3, 1'b1, 10, "short_latch");
        repeat (10) @(negedge clock);
        check("short_held", 8'h01, fault_latched);
        @(posedge clock) output_short <= 1'b0;
        restart();
        $display("t_faults done");
    endtask
    task automatic t_timeout();
        @(posedge clock) enable_pin <= 1'b0;
        repeat (60) @(negedge clock);
        check("off_state", 8'h01, flags[2:1]);
        @(posedge clock) output_short <= 1'b1;
        enable_pin <= 1'b1;
        for (k = 0; k < 130 && fault_latched !== 1'b1; k++)
        begin
            @(negedge clock);
            if (isolation_gate_high !== 1'b1) check("gate_kept_off", 8'h01, 8'h00);
        end
        check("timeout_at", 8'h01, {7'h00, k > 95 && fault_latched === 1'b1});
        @(posedge clock) output_short <= 1'b0;
        restart();
        @(posedge clock) battery_ok <= 1'b0;
        repeat (6) @(negedge clock);
        check("uvlo_off", 8'h00, switch_enable);
        @(posedge clock) battery_ok <= 1'b1;
        wait_for(2, 1'b1, 300, "uvlo_restart");
        $display("t_timeout done");
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        t_start();
        t_strings();
        t_faults();
        t_timeout();
        test_done();
    end
    initial
    begin
        repeat (60000) @(posedge clock);
        error_cnt++;
        test_done();
    end
endmodule
